// file: hdl/ext_reg_defs.svh
`ifndef EXT_REG_DEFS_SVH
`define EXT_REG_DEFS_SVH
`define EXT_CTRL_ADDR 5'h0D
`define EXT_DATA_ADDR 5'h0E
`define LDROP_STATUS_ADDR 5'h0F
`define DIRECT_TOP 5'h1F
`define FUNC_MSB 15
`define FUNC_LSB 14
`define TARGET_DEVICE_ADDRESS_MSB 4
`define TARGET_DEVICE_ADDRESS_LSB 0
`define OWN_TARGET_DEVICE_ADDRESS 5'h1F
`define STATUS_LSB 4
`define STATUS_MSB 8
`define CTRL_RESET 16'h0000
`define DATA_RESET 16'h0000
`define STATUS_RESET 5'h00
`define RXERR_LIMIT 32
`define MLT3_LIMIT 20
`define SNR_LIMIT 20
`define WINDOW_NS 10000
`define CLK_PERIOD_NS 100
`define WINDOW_CYCLES (`WINDOW_NS / `CLK_PERIOD_NS)
`endif

// file: hdl/ext_reg_pkg.sv
package ext_reg_pkg;
    typedef enum logic [1:0] {
        FUNC_ADDRESS,
        FUNC_DATA_HOLD,
        FUNC_DATA_INC_RW,
        FUNC_DATA_INC_WR
    } func_e;
    typedef struct packed {
        logic descrambler_loss;
        logic rx_errors;
        logic line_code_errors;
        logic low_snr;
        logic energy_loss;
    } drop_cause_s;
endpackage

// file: hdl/indirect_ext_reg_access.sv
`timescale 1ns/1ps
`include "ext_reg_defs.svh"
module indirect_ext_reg_access #(
    parameter int EXT_ADDR_W = 8,
    parameter int WINDOW_CYCLES = `WINDOW_CYCLES,
    parameter int RXERR_LIMIT = `RXERR_LIMIT,
    parameter int MLT3_LIMIT = `MLT3_LIMIT,
    parameter int SNR_LIMIT = `SNR_LIMIT
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Management register port, one-cycle strobes
    input wire logic [4:0] mgmt_addr,
    input wire logic mgmt_wr,
    input wire logic mgmt_rd,
    input wire logic [15:0] mgmt_wdata,
    output logic [15:0] mgmt_rdata,
    output logic mgmt_rvalid,
    // Extended register space port
    output logic [15:0] ext_addr,
    output logic ext_wr,
    output logic ext_rd,
    output logic [15:0] ext_wdata,
    input wire logic [15:0] ext_rdata,
    // Fast link drop enables and events
    input wire logic [4:0] drop_enable,
    input wire logic descrambler_loss,
    input wire logic rx_error_event,
    input wire logic line_code_event,
    input wire logic snr_event,
    input wire logic energy_loss,
    output logic link_drop
);
    logic [1:0] func;
    logic [4:0] target_device_address;
    logic [15:0] pointer;
    ext_reg_pkg::drop_cause_s drop_cause;
    logic [$clog2(WINDOW_CYCLES+1)-1:0] win_cnt;
    logic [5:0] rx_cnt;
    logic [5:0] mlt3_cnt;
    logic [5:0] snr_cnt;

    wire sel_ctrl = mgmt_addr == `EXT_CTRL_ADDR;
    wire sel_data = mgmt_addr == `EXT_DATA_ADDR;
    wire sel_stat = mgmt_addr == `LDROP_STATUS_ADDR;
    wire dev_ok = target_device_address == `OWN_TARGET_DEVICE_ADDRESS;
    wire func_addr = func == 2'(ext_reg_pkg::FUNC_ADDRESS);
    wire data_wr = mgmt_wr && sel_data && dev_ok;
    wire data_rd = mgmt_rd && sel_data && dev_ok;
    wire inc_rw = func == 2'(ext_reg_pkg::FUNC_DATA_INC_RW);
    wire inc_wr = func == 2'(ext_reg_pkg::FUNC_DATA_INC_WR);
    // Post-increment policy per function code
    wire bump = !func_addr && ((inc_rw && (data_wr || data_rd)) || (inc_wr && data_wr));
    wire win_end = win_cnt == ($clog2(WINDOW_CYCLES+1))'(WINDOW_CYCLES - 1);

    // Rx error, line code and SNR criteria fire on count thresholds within each window
    wire rx_fire = rx_error_event && rx_cnt == 6'(RXERR_LIMIT - 1);
    wire mlt3_fire = line_code_event && mlt3_cnt == 6'(MLT3_LIMIT - 1);
    wire snr_fire = snr_event && snr_cnt == 6'(SNR_LIMIT - 1);
    ext_reg_pkg::drop_cause_s fired;
    assign fired = '{descrambler_loss, rx_fire, mlt3_fire, snr_fire, energy_loss};
    wire [4:0] drops = fired & drop_enable;
    wire stat_rd = mgmt_rd && sel_stat;

    wire [15:0] ctrl_view = {func, 9'h000, target_device_address};
    wire [15:0] data_view = func_addr ? pointer : ext_rdata;
    wire [15:0] stat_view = {7'h00, drop_cause, 4'h0};
    wire [15:0] next_rdata = sel_ctrl ? ctrl_view : (sel_data && dev_ok) ? data_view :
        sel_stat ? stat_view : 16'h0000;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            func <= 2'h0;
            target_device_address <= 5'h00;
        end else if (mgmt_wr && sel_ctrl) begin
            func <= mgmt_wdata[`FUNC_MSB:`FUNC_LSB];
            target_device_address <= mgmt_wdata[`TARGET_DEVICE_ADDRESS_MSB:`TARGET_DEVICE_ADDRESS_LSB];
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pointer <= `DATA_RESET;
        end else if (data_wr && func_addr) begin
            pointer <= mgmt_wdata;
        end else if (bump) begin
            pointer <= pointer + 16'h0001;
        end
    end

    // Pointed access strobes; pointer unchanged in hold mode
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ext_addr <= 16'h0000;
            ext_wr <= 1'b0;
            ext_rd <= 1'b0;
            ext_wdata <= 16'h0000;
        end else begin
            ext_addr <= pointer;
            ext_wr <= data_wr && !func_addr;
            ext_rd <= data_rd && !func_addr;
            ext_wdata <= mgmt_wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            mgmt_rdata <= 16'h0000;
            mgmt_rvalid <= 1'b0;
        end else begin
            mgmt_rdata <= next_rdata;
            mgmt_rvalid <= mgmt_rd;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            win_cnt <= '0;
            rx_cnt <= 6'h00;
            mlt3_cnt <= 6'h00;
            snr_cnt <= 6'h00;
        end else if (win_end) begin
            win_cnt <= '0;
            rx_cnt <= 6'h00;
            mlt3_cnt <= 6'h00;
            snr_cnt <= 6'h00;
        end else begin
            win_cnt <= win_cnt + 1'b1;
            rx_cnt <= rx_fire ? 6'h00 : rx_cnt + 6'(rx_error_event);
            mlt3_cnt <= mlt3_fire ? 6'h00 : mlt3_cnt + 6'(line_code_event);
            snr_cnt <= snr_fire ? 6'h00 : snr_cnt + 6'(snr_event);
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            drop_cause <= `STATUS_RESET;
            link_drop <= 1'b0;
        end else begin
            drop_cause <= (stat_rd ? 5'h00 : drop_cause) | drops;
            link_drop <= |drops;
        end
    end
endmodule

// file: bench/indirect_ext_reg_access_properties.sv
`timescale 1ns/1ps
module indirect_ext_reg_access_properties (
    input wire logic sys_clk, resetn, mgmt_wr, mgmt_rd, mgmt_rvalid, ext_wr, ext_rd,
    input wire logic energy_loss, descrambler_loss, link_drop,
    input wire logic [4:0] mgmt_addr, drop_enable,
    input wire logic [15:0] mgmt_rdata
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence s_ctrl_rd; mgmt_rd && mgmt_addr == 5'h0D; endsequence
    sequence s_stat_rd; mgmt_rd && mgmt_addr == 5'h0F; endsequence
    a_read_answer: assert property (mgmt_rd |=> mgmt_rvalid) else $error("no answer");
    a_answer_cause: assert property (mgmt_rvalid |-> $past(mgmt_rd)) else $error("stray answer");
    a_ext_wr_cause: assert property (ext_wr |-> $past(mgmt_wr && mgmt_addr == 5'h0E)) else $error("ext wr");
    a_ext_rd_cause: assert property (ext_rd |-> $past(mgmt_rd && mgmt_addr == 5'h0E)) else $error("ext rd");
    a_ctrl_reserved: assert property (s_ctrl_rd |=> mgmt_rdata[13:5] == 9'h000) else $error("ctrl gap");
    a_stat_reserved: assert property (s_stat_rd |=> mgmt_rdata[15:9] == 7'h00 && mgmt_rdata[3:0] == 4'h0)
        else $error("status gap");
    a_drop_level: assert property ((drop_enable[0] && energy_loss) || (drop_enable[4] && descrambler_loss)
        |=> link_drop) else $error("no drop");
    a_drop_cause: assert property (link_drop |-> $past(|drop_enable)) else $error("drop off");
endmodule
bind indirect_ext_reg_access indirect_ext_reg_access_properties props_u (.*);

// file: bench/ext_space_model.sv
`timescale 1ns/1ps
module ext_space_model (
    input wire logic sys_clk, resetn, ext_rd,
    output logic [15:0] ext_rdata
);
    logic [7:0] reads;
    // Answer tag advances per completed read
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) reads <= 8'h00;
        else if (ext_rd) reads <= reads + 8'h01;
    end
    assign ext_rdata = {8'hA5, reads};
endmodule

// file: bench/indirect_ext_reg_access_tb.sv
`timescale 1ns/1ps
module indirect_ext_reg_access_tb;
    logic sys_clk = 0, resetn = 0, mgmt_wr = 0, mgmt_rd = 0, mgmt_rvalid, ext_wr, ext_rd, link_drop;
    logic [4:0] mgmt_addr = 0, drop_enable = 0, ev = 0;
    logic [15:0] mgmt_wdata = 0, mgmt_rdata, ext_addr, ext_wdata, ext_rdata, r = 16'h000B, p, d;
    int bad_count = 0, checks_done = 0, rc = 0;
    indirect_ext_reg_access #(.WINDOW_CYCLES(20), .RXERR_LIMIT(4), .MLT3_LIMIT(3), .SNR_LIMIT(3)) dut_u (.*,
        .descrambler_loss(ev[4]), .rx_error_event(ev[3]), .line_code_event(ev[2]), .snr_event(ev[1]),
        .energy_loss(ev[0]));
    ext_space_model model_u (.*);
    initial forever #50 sys_clk = ~sys_clk;
    function automatic logic [15:0] nx(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(logic [15:0] got, logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic acc(logic w, logic [4:0] a, logic [15:0] v);
        mgmt_addr = a;
        mgmt_wdata = v;
        mgmt_wr = w;
        mgmt_rd = !w;
        @(posedge sys_clk);
        #5 mgmt_wr = 0;
        mgmt_rd = 0;
    endtask
    task finish_test;
        if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #200000 bad_count++;
        finish_test;
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        #5 resetn = 1;
        acc(0, 5'h0D, 0); chk(mgmt_rdata, 0);
        acc(1, 5'h0D, 16'hFFFF);
        acc(0, 5'h0D, 0); chk(mgmt_rdata, 16'hC01F);
        acc(0, 5'h03, 0); chk(mgmt_rdata, 0);
        for (int f = 0; f < 4; f++) begin
            r = nx(r);
            p = r;
            r = nx(r);
            d = r;
            acc(1, 5'h0D, 16'h001F);
            acc(1, 5'h0E, p); chk(ext_wr, 0);
            acc(1, 5'h0D, {f[1:0], 14'h001F});
            acc(1, 5'h0E, d); chk(ext_wr, f != 0);
            chk(f ? ext_addr : p, p); chk(f ? ext_wdata : d, d);
            p = f ? p + (f > 1) : d;
            acc(0, 5'h0E, 0); chk(mgmt_rdata, f ? {8'hA5, rc[7:0]} : p);
            chk(f ? ext_addr : p, p); chk(ext_rd, f != 0);
            p = p + (f == 2);
            acc(0, 5'h0E, 0); chk(f ? ext_addr : p, p);
            rc += f ? 2 : 0;
        end
        acc(1, 5'h0D, 16'h401E);
        acc(1, 5'h0E, d); chk(ext_wr, 0);
        acc(0, 5'h0E, 0); chk(mgmt_rdata, 0);
        for (int i = 0; i < 6; i++) begin
            drop_enable = 5'h01 << i;
            ev = drop_enable | {5{i == 5}};
            repeat (8) @(posedge sys_clk);
            #5 ev = 0;
            @(posedge sys_clk);
            #5 acc(0, 5'h0F, 0); chk(mgmt_rdata, {7'h00, drop_enable, 4'h0});
            acc(0, 5'h0F, 0); chk(mgmt_rdata, 0);
        end
        finish_test;
    end
endmodule
